// [rtl/commutation_offset_manager.v]
`timescale 1ns/10ps
`include "commutation_offset_manager_consts.vh"

module commutation_offset_manager (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output reg [31:0] hrdata,
   output wire hresp,
   input wire [15:0] enc_position,
   input wire enc_startup,
   output reg enc_req,
   output reg [1:0] enc_op,
   output reg [15:0] enc_wdata,
   input wire enc_done,
   input wire enc_ok,
   input wire [15:0] enc_rdata,
   input wire [15:0] drive_offset,
   input wire drive_offset_ok,
   output reg align_start,
   input wire align_done,
   input wire align_ok,
   input wire [15:0] align_offset,
   input wire enable_req,
   input wire disable_req,
   output reg axis_enabled,
   output reg enable_error,
   output reg [23:0] elec_angle
);

   // One-hot sequencer states
   localparam S_IDLE = 6'b000001;
   localparam S_FETCH = 6'b000010;
   localparam S_ALIGN = 6'b000100;
   localparam S_STORE = 6'b001000;
   localparam S_REZERO = 6'b010000;
   localparam S_CLEAR = 6'b100000;

   // What follows a successful alignment
   localparam F_NONE = 2'h0;
   localparam F_STORE = 2'h1;
   localparam F_REZERO = 2'h2;

   reg [5:0] state_r;
   reg [2:0] status_r;
   reg [15:0] offset_r;
   reg [4:0] config_r;
   reg [7:0] poles_r;
   reg err_missing_r;
   reg err_enable_r;
   reg [1:0] follow_r;
   reg keep_en_r;
   reg cmd_driven_r;
   reg wr_pend_r;
   reg [5:0] wr_addr_r;

   wire [1:0] src_sel;
   wire [1:0] align_sel;
   wire no_search;
   wire addr_phase;
   wire [5:0] a_low;
   wire wr_cmd;
   wire [3:0] cmd_code;
   wire wr_status;
   wire clr_missing;
   wire clr_enable;
   wire idle;

   assign src_sel = config_r[`CFG_SRC_MSB:`CFG_SRC_LSB];
   assign align_sel = config_r[`CFG_ALIGN_MSB:`CFG_ALIGN_LSB];
   assign no_search = config_r[`CFG_NO_SEARCH];
   assign idle = state_r == S_IDLE;

   // Zero-wait slave, every answer OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel & htrans[1] & hready;
   assign a_low = {haddr[5:2], 2'b00};

   // Write decodes act in the data phase, when hwdata is on the bus
   assign wr_cmd = wr_pend_r & (wr_addr_r == `REG_COMMAND);
   assign cmd_code = hwdata[3:0];
   assign wr_status = wr_pend_r & (wr_addr_r == `REG_STATUS);
   assign clr_missing = wr_status & hwdata[`STAT_ERR_MISSING];
   assign clr_enable = wr_status & hwdata[`STAT_ERR_ENABLE];

   // Electrical angle: signed mechanical error times pole pairs
   function [23:0] elec_of;
      input [15:0] pos;
      input [15:0] off;
      input [7:0] pp;
      reg [15:0] diff;
      begin
         diff = pos - off;
         elec_of = $signed(diff) * $signed({1'b0, pp});
      end
   endfunction

   // Read mux for the data phase
   function [31:0] read_word;
      input [5:0] a;
      begin
         case (a)
            `REG_CONFIG: read_word = {27'h000_0000, config_r};
            `REG_POLES: read_word = {24'h00_0000, poles_r};
            `REG_STATUS: read_word = {20'h0_0000, axis_enabled,
               ~idle, err_enable_r, err_missing_r, 5'h00, status_r};
            `REG_OFFSET: read_word = {16'h0000, offset_r};
            `REG_ANGLE: read_word = {{8{elec_angle[23]}}, elec_angle};
            default: read_word = 32'h0000_0000;
         endcase
      end
   endfunction

   // Bus capture; read data latched so it stands for the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 6'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend_r <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_r <= a_low;
         end
         if (addr_phase & ~hwrite) begin
            hrdata <= read_word(a_low);
         end
      end
   end

   // Configuration registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         config_r <= `CFG_RESET;
         poles_r <= `POLES_RESET;
      end else begin
         if (wr_pend_r & (wr_addr_r == `REG_CONFIG)) begin
            config_r <= hwdata[4:0];
         end
         if (wr_pend_r & (wr_addr_r == `REG_POLES)) begin
            poles_r <= hwdata[7:0];
         end
      end
   end

   // Angle follows position every cycle; offset is zero for absolute
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         elec_angle <= 24'h00_0000;
      end else if (src_sel == `SRC_ABS_POSITION) begin
         elec_angle <= elec_of(enc_position, 16'h0000, poles_r);
      end else begin
         elec_angle <= elec_of(enc_position, offset_r, poles_r);
      end
   end

   // Sequencer: fetch, alignment, encoder writes and axis enable.
   // Commands that arrive while busy are dropped, so a store can never
   // be torn by a second alignment.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= S_IDLE;
         status_r <= `ST_INVALID;
         offset_r <= 16'h0000;
         err_missing_r <= 1'b0;
         err_enable_r <= 1'b0;
         follow_r <= F_NONE;
         keep_en_r <= 1'b0;
         cmd_driven_r <= 1'b0;
         enc_req <= 1'b0;
         enc_op <= `ENC_FETCH;
         enc_wdata <= 16'h0000;
         align_start <= 1'b0;
         axis_enabled <= 1'b0;
         enable_error <= 1'b0;
      end else begin
         align_start <= 1'b0;
         enable_error <= 1'b0;
         // Software clears, hardware sets below win the same cycle
         if (clr_missing) begin
            err_missing_r <= 1'b0;
         end
         if (clr_enable) begin
            err_enable_r <= 1'b0;
         end
         if (disable_req) begin
            axis_enabled <= 1'b0;
            keep_en_r <= 1'b0;
         end
         case (state_r)
            S_IDLE: begin
               if (no_search) begin
                  status_r <= `ST_DISABLED;
               end else if (status_r == `ST_DISABLED) begin
                  status_r <= `ST_INVALID;
               end
               if (enc_startup & ~no_search) begin
                  case (src_sel)
                     `SRC_ABS_POSITION: begin
                        status_r <= `ST_VALID;
                        offset_r <= 16'h0000;
                     end
                     `SRC_OFFSET_SENSOR: begin
                        enc_req <= 1'b1;
                        enc_op <= `ENC_FETCH;
                        state_r <= S_FETCH;
                     end
                     `SRC_OFFSET_DRIVE: begin
                        if (drive_offset_ok) begin
                           offset_r <= drive_offset;
                           status_r <= `ST_VALID;
                        end else begin
                           status_r <= `ST_INVALID;
                           err_missing_r <= 1'b1;
                        end
                     end
                     default: begin
                        status_r <= `ST_INVALID;
                     end
                  endcase
               end else if (wr_cmd & ~no_search) begin
                  case (cmd_code)
                     `CMD_CLEAR_ALIGN: begin
                        status_r <= `ST_INVALID;
                     end
                     `CMD_BEGIN_ALIGN, `CMD_ALIGN_STORE,
                     `CMD_ALIGN_REZERO: begin
                        keep_en_r <= axis_enabled;
                        cmd_driven_r <= 1'b1;
                        axis_enabled <= 1'b1;
                        align_start <= 1'b1;
                        status_r <= `ST_PHASING;
                        state_r <= S_ALIGN;
                        if (cmd_code == `CMD_ALIGN_STORE) begin
                           follow_r <= F_STORE;
                        end else if (cmd_code == `CMD_ALIGN_REZERO) begin
                           follow_r <= F_REZERO;
                        end else begin
                           follow_r <= F_NONE;
                        end
                     end
                     `CMD_CLEAR_REMOTE: begin
                        enc_req <= 1'b1;
                        enc_op <= `ENC_CLEAR;
                        state_r <= S_CLEAR;
                     end
                     default: begin
                        state_r <= S_IDLE;
                     end
                  endcase
               end else if (enable_req & ~disable_req & ~axis_enabled) begin
                  if (no_search | (status_r == `ST_VALID)) begin
                     axis_enabled <= 1'b1;
                  end else if (align_sel == `ALIGN_NONE) begin
                     err_enable_r <= 1'b1;
                     enable_error <= 1'b1;
                  end else begin
                     // Alignment on behalf of an enable ends enabled if it succeeds, disabled if it fails
                     keep_en_r <= 1'b1;
                     cmd_driven_r <= 1'b0;
                     follow_r <= F_NONE;
                     axis_enabled <= 1'b1;
                     align_start <= 1'b1;
                     status_r <= `ST_PHASING;
                     state_r <= S_ALIGN;
                  end
               end else if (enable_req & no_search & ~disable_req) begin
                  axis_enabled <= 1'b1;
               end
            end
            S_FETCH: begin
               if (enc_done) begin
                  enc_req <= 1'b0;
                  state_r <= S_IDLE;
                  if (enc_ok) begin
                     offset_r <= enc_rdata;
                     status_r <= `ST_VALID;
                  end else begin
                     status_r <= `ST_INVALID;
                     err_missing_r <= 1'b1;
                  end
               end
            end
            S_ALIGN: begin
               if (align_done) begin
                  if (align_ok) begin
                     offset_r <= align_offset;
                     status_r <= `ST_VALID;
                     if (follow_r == F_STORE) begin
                        enc_req <= 1'b1;
                        enc_op <= `ENC_STORE;
                        enc_wdata <= align_offset;
                        status_r <= `ST_HOLD;
                        state_r <= S_STORE;
                     end else if (follow_r == F_REZERO) begin
                        enc_req <= 1'b1;
                        enc_op <= `ENC_REZERO;
                        enc_wdata <= align_offset;
                        state_r <= S_REZERO;
                     end else begin
                        axis_enabled <= keep_en_r;
                        state_r <= S_IDLE;
                     end
                  end else begin
                     // Failed alignment: host must retry
                     status_r <= `ST_INVALID;
                     axis_enabled <= cmd_driven_r & keep_en_r;
                     state_r <= S_IDLE;
                  end
               end
            end
            S_STORE: begin
               if (enc_done) begin
                  enc_req <= 1'b0;
                  status_r <= `ST_VALID;
                  axis_enabled <= keep_en_r;
                  state_r <= S_IDLE;
               end
            end
            S_REZERO: begin
               if (enc_done) begin
                  enc_req <= 1'b0;
                  // Encoder zero now sits on commutation zero
                  if (enc_ok) begin
                     offset_r <= 16'h0000;
                  end
                  status_r <= `ST_VALID;
                  axis_enabled <= keep_en_r;
                  state_r <= S_IDLE;
               end
            end
            S_CLEAR: begin
               if (enc_done) begin
                  enc_req <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
               enc_req <= 1'b0;
            end
         endcase
      end
   end

endmodule

// [rtl/commutation_offset_manager_consts.vh]
`ifndef COMMUTATION_OFFSET_MANAGER_CONSTS_VH
`define COMMUTATION_OFFSET_MANAGER_CONSTS_VH

// Register byte offsets
`define REG_CONFIG 6'h00
`define REG_POLES 6'h04
`define REG_COMMAND 6'h08
`define REG_STATUS 6'h0C
`define REG_OFFSET 6'h10
`define REG_ANGLE 6'h14

// Configuration field positions
`define CFG_SRC_LSB 0
`define CFG_SRC_MSB 1
`define CFG_ALIGN_LSB 2
`define CFG_ALIGN_MSB 3
`define CFG_NO_SEARCH 4
`define CFG_RESET 5'h00
`define POLES_RESET 8'h01

// Commutation source select
`define SRC_RELATIVE 2'h0
`define SRC_ABS_POSITION 2'h1
`define SRC_OFFSET_SENSOR 2'h2
`define SRC_OFFSET_DRIVE 2'h3

// Alignment method
`define ALIGN_NONE 2'h0
`define ALIGN_ROTOR_PULL 2'h1

// Command codes
`define CMD_CLEAR_ALIGN 4'h1
`define CMD_BEGIN_ALIGN 4'h2
`define CMD_ALIGN_STORE 4'h3
`define CMD_ALIGN_REZERO 4'h4
`define CMD_CLEAR_REMOTE 4'h5

// Commutation status codes
`define ST_DISABLED 3'h0
`define ST_INVALID 3'h1
`define ST_PHASING 3'h2
`define ST_HOLD 3'h3
`define ST_VALID 3'h4

// Status register bit positions
`define STAT_ERR_MISSING 8
`define STAT_ERR_ENABLE 9
`define STAT_BUSY 10
`define STAT_AXIS_EN 11

// Encoder operation codes
`define ENC_FETCH 2'h0
`define ENC_STORE 2'h1
`define ENC_REZERO 2'h2
`define ENC_CLEAR 2'h3

`endif

// [verif/commutation_offset_manager_monitor.sv]
`timescale 1ns/10ps
`include "commutation_offset_manager_consts.vh"

module commutation_offset_manager_monitor (
   input wire hclk,
   input wire hresetn,
   input wire hresp,
   input wire enc_req,
   input wire [1:0] enc_op,
   input wire [15:0] enc_wdata,
   input wire enc_done,
   input wire align_start,
   input wire enable_req,
   input wire axis_enabled,
   input wire enable_error
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Encoder request must not wobble while the far side works on it
   hold_stable_a: assert property (enc_req && !enc_done |=>
      enc_req && $stable(enc_op) && $stable(enc_wdata))
      else $error("encoder request changed before done");
   enc_drop_a: assert property (enc_req && enc_done |=> !enc_req)
      else $error("encoder request held after done");
   align_pulse_a: assert property (align_start |=> !align_start)
      else $error("alignment start longer than one cycle");
   err_cause_a: assert property (enable_error |->
      $past(enable_req))
      else $error("enable error without enable request");
   err_once_a: assert property (enable_error |=> !enable_error)
      else $error("enable error longer than one cycle");
   // Alignment needs the power stage on, whatever the prior state
   axis_forced_a: assert property ($rose(align_start) |->
      ##[0:2] axis_enabled)
      else $error("axis not enabled during alignment");
   store_freeze_a: assert property (enc_req &&
      enc_op == `ENC_STORE |-> !align_start)
      else $error("alignment restarted during offset store");
   hresp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
endmodule

bind commutation_offset_manager commutation_offset_manager_monitor mon (
   .hclk(hclk), .hresetn(hresetn), .hresp(hresp), .enc_req(enc_req),
   .enc_op(enc_op), .enc_wdata(enc_wdata), .enc_done(enc_done),
   .align_start(align_start), .enable_req(enable_req),
   .axis_enabled(axis_enabled), .enable_error(enable_error));

// [verif/enc_model.sv]
`timescale 1ns/10ps
`include "commutation_offset_manager_consts.vh"

module enc_model (
   input wire hclk,
   input wire hresetn,
   input wire enc_req,
   input wire [1:0] enc_op,
   input wire [15:0] enc_wdata,
   input wire slow,
   output reg enc_done,
   output reg enc_ok,
   output reg [15:0] enc_rdata
);
   // Nonvolatile, so untouched by the drive's reset
   reg [15:0] mem = 16'h0000;
   reg valid = 1'b0;
   integer cnt;
   integer rezeros = 0;

   // Answer after a short or long delay; idle enc_ok and enc_rdata toggle every cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enc_done <= 1'b0;
         enc_ok <= 1'b0;
         enc_rdata <= 16'h0000;
         cnt <= 0;
      end else begin
         enc_done <= 1'b0;
         enc_ok <= ~enc_ok;
         enc_rdata <= ~enc_rdata;
         if (enc_req && !enc_done && cnt == 0) begin
            cnt <= slow ? 12 : 2;
         end else if (cnt == 1) begin
            cnt <= 0;
            enc_done <= 1'b1;
            enc_ok <= 1'b1;
            enc_rdata <= mem;
            case (enc_op)
               `ENC_FETCH: enc_ok <= valid;
               `ENC_STORE: begin
                  mem <= enc_wdata;
                  valid <= 1'b1;
               end
               `ENC_REZERO: rezeros <= rezeros + 1;
               default: valid <= 1'b0;
            endcase
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

// [verif/test_commutation_offset_manager.sv]
`timescale 1ns/10ps
`include "commutation_offset_manager_consts.vh"

module test_commutation_offset_manager;
   reg hclk, hresetn, hsel, hwrite, enc_startup, drive_offset_ok, slow;
   reg align_done, align_ok, enable_req, disable_req;
   reg [31:0] haddr, hwdata, q;
   reg [1:0] htrans;
   reg [2:0] hsize;
   reg [15:0] enc_position, drive_offset, align_offset, aoff;
   reg [7:0] poles;
   wire hreadyout, hresp, enc_req, enc_done, enc_ok, align_start;
   wire axis_enabled, enable_error;
   wire [31:0] hrdata;
   wire [1:0] enc_op;
   wire [15:0] enc_wdata, enc_rdata;
   wire [23:0] elec_angle;
   integer n_fail, comparisons, acnt, n_al, n_err, e, v;

   commutation_offset_manager uut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .enc_position(enc_position), .enc_startup(enc_startup),
      .enc_req(enc_req), .enc_op(enc_op), .enc_wdata(enc_wdata),
      .enc_done(enc_done), .enc_ok(enc_ok), .enc_rdata(enc_rdata),
      .drive_offset(drive_offset), .drive_offset_ok(drive_offset_ok),
      .align_start(align_start), .align_done(align_done),
      .align_ok(align_ok), .align_offset(align_offset),
      .enable_req(enable_req), .disable_req(disable_req),
      .axis_enabled(axis_enabled), .enable_error(enable_error),
      .elec_angle(elec_angle));
   enc_model enc (.hclk(hclk), .hresetn(hresetn), .enc_req(enc_req),
      .enc_op(enc_op), .enc_wdata(enc_wdata), .slow(slow),
      .enc_done(enc_done), .enc_ok(enc_ok), .enc_rdata(enc_rdata));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // Alignment engine stand-in; offset shows the inverse of aoff outside its valid cycle
   always @(posedge hclk) begin
      align_done <= 1'b0;
      align_offset <= ~aoff;
      if (align_start) begin
         acnt <= 6;
         n_al <= n_al + 1;
      end else if (acnt == 1) begin
         acnt <= 0;
         align_done <= 1'b1;
         align_offset <= aoff;
      end else if (acnt > 1) acnt <= acnt - 1;
      if (enable_error) n_err <= n_err + 1;
   end

   task chk(input [31:0] s, input [31:0] x);
      begin
         comparisons = comparisons + 1;
         if (s !== x) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
         end
      end
   endtask

   // One single AHB transfer; entered just after a rising edge
   task bus(input [5:0] a, input w, input [31:0] d);
      begin
         hsel <= 1'b1;
         haddr <= {26'h000_0000, a};
         hwrite <= w;
         htrans <= 2'b10;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         q = hrdata;
      end
   endtask

   task pulse(input integer k);
      begin
         if (k == 0) enc_startup <= 1'b1;
         else if (k == 1) enable_req <= 1'b1;
         else disable_req <= 1'b1;
         @(posedge hclk);
         enc_startup <= 1'b0;
         enable_req <= 1'b0;
         disable_req <= 1'b0;
      end
   endtask

   task wait_idle;
      integer i;
      begin
         repeat (2) @(posedge hclk);
         bus(`REG_STATUS, 1'b0, 32'h0000_0000);
         for (i = 0; i < 100 && q[`STAT_BUSY] !== 1'b0; i = i + 1)
            bus(`REG_STATUS, 1'b0, 32'h0000_0000);
         if (i == 100) chk(1, 0);
      end
   endtask

   // Expected status code and offset after an operation settles
   task expect_st(input [2:0] st, input [15:0] off);
      begin
         wait_idle;
         chk(q[2:0], st);
         bus(`REG_OFFSET, 1'b0, 32'h0000_0000);
         chk(q, {16'h0000, off});
      end
   endtask

   // Reference angle: signed position difference times pole pairs
   function [31:0] ang(input [15:0] p, input [15:0] o, input [7:0] n);
      reg signed [15:0] s;
      integer i;
      begin
         s = p - o;
         i = s;
         ang = i * n;
      end
   endfunction

   task wrap_up;
      begin
         $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      n_fail = n_fail + 1;
      wrap_up;
   end

   initial begin
      {hsel, hwrite, enc_startup, drive_offset_ok, slow} = 5'h00;
      {enable_req, disable_req, align_ok} = 3'h1;
      {haddr, hwdata, htrans, acnt, n_al, n_err} = 0;
      {enc_position, drive_offset, aoff} = 0;
      hsize = 3'h2;
      hresetn = 1'b0;
      n_fail = 0;
      comparisons = 0;
      v = $urandom(32'h018b);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      bus(`REG_STATUS, 1'b0, 32'h0000_0000);
      chk(q[2:0], `ST_INVALID);
      bus(`REG_POLES, 1'b0, 32'h0000_0000);
      chk(q, 32'h0000_0001);
      bus(6'h3c, 1'b0, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      $display("Test reset done");
      poles = $urandom_range(255, 1);
      enc_position <= $urandom;
      bus(`REG_CONFIG, 1'b1, 32'h0000_0005);
      bus(`REG_POLES, 1'b1, {24'h00_0000, poles});
      pulse(0);
      expect_st(`ST_VALID, 16'h0000);
      bus(`REG_ANGLE, 1'b0, 32'h0000_0000);
      chk(q, ang(enc_position, 16'h0000, poles));
      chk({{8{elec_angle[23]}}, elec_angle},
         ang(enc_position, 16'h0000, poles));
      pulse(1);
      @(posedge hclk);
      chk(axis_enabled, 1'b1);
      chk(n_al, 0);
      pulse(2);
      bus(`REG_COMMAND, 1'b1, `CMD_CLEAR_ALIGN);
      expect_st(`ST_INVALID, 16'h0000);
      for (e = 0; e < 2; e = e + 1) begin
         if (e == 1) pulse(1);
         aoff = $urandom;
         bus(`REG_COMMAND, 1'b1, `CMD_BEGIN_ALIGN);
         expect_st(`ST_VALID, aoff);
         chk(axis_enabled, e);
      end
      // Failed alignment keeps the prior enable; the host then retries
      align_ok <= 1'b0;
      bus(`REG_COMMAND, 1'b1, `CMD_BEGIN_ALIGN);
      expect_st(`ST_INVALID, aoff);
      chk(axis_enabled, 1'b1);
      align_ok <= 1'b1;
      aoff = $urandom;
      bus(`REG_COMMAND, 1'b1, `CMD_BEGIN_ALIGN);
      expect_st(`ST_VALID, aoff);
      pulse(2);
      $display("Test alignment done");
      slow <= 1'b1;
      aoff = $urandom;
      bus(`REG_COMMAND, 1'b1, `CMD_ALIGN_STORE);
      for (e = 0; e < 50 && enc_req !== 1'b1; e = e + 1) @(posedge hclk);
      bus(`REG_STATUS, 1'b0, 32'h0000_0000);
      chk(q[2:0], `ST_HOLD);
      expect_st(`ST_VALID, aoff);
      chk(enc.mem, aoff);
      slow <= 1'b0;
      // Restart mid-run: the offset kept in the encoder must come back
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(`REG_STATUS, 1'b0, 32'h0000_0000);
      chk(q[2:0], `ST_INVALID);
      chk(axis_enabled, 1'b0);
      bus(`REG_CONFIG, 1'b1, 32'h0000_0006);
      pulse(0);
      expect_st(`ST_VALID, aoff);
      bus(`REG_ANGLE, 1'b0, 32'h0000_0000);
      chk(q, ang(enc_position, aoff, 8'h01));
      $display("Test store done");
      bus(`REG_COMMAND, 1'b1, `CMD_CLEAR_REMOTE);
      wait_idle;
      chk(enc.valid, 1'b0);
      bus(`REG_COMMAND, 1'b1, `CMD_CLEAR_ALIGN);
      bus(`REG_CONFIG, 1'b1, 32'h0000_0002);
      pulse(0);
      wait_idle;
      chk(q[`STAT_ERR_MISSING], 1'b1);
      bus(`REG_STATUS, 1'b1, 32'h0000_0100);
      bus(`REG_STATUS, 1'b0, 32'h0000_0000);
      chk(q[`STAT_ERR_MISSING], 1'b0);
      pulse(1);
      wait_idle;
      chk(n_err, 1);
      chk(q[`STAT_ERR_ENABLE], 1'b1);
      chk(axis_enabled, 1'b0);
      bus(`REG_CONFIG, 1'b1, 32'h0000_0006);
      aoff = $urandom;
      pulse(1);
      @(posedge hclk);
      bus(`REG_STATUS, 1'b0, 32'h0000_0000);
      chk(q[2:0], `ST_PHASING);
      expect_st(`ST_VALID, aoff);
      chk(axis_enabled, 1'b1);
      pulse(2);
      $display("Test fetch failure done");
      // The drive image is persisted only while status reads Valid
      bus(`REG_STATUS, 1'b0, 32'h0000_0000);
      if (q[2:0] === `ST_VALID) drive_offset_ok <= 1'b1;
      drive_offset <= $urandom;
      bus(`REG_CONFIG, 1'b1, 32'h0000_0007);
      pulse(0);
      expect_st(`ST_VALID, drive_offset);
      bus(`REG_COMMAND, 1'b1, `CMD_ALIGN_REZERO);
      expect_st(`ST_VALID, 16'h0000);
      chk(enc.rezeros, 1);
      $display("Test drive and rezero done");
      // No angle search: status Disabled, commands ignored, enable direct
      v = n_al;
      bus(`REG_CONFIG, 1'b1, 32'h0000_0010);
      wait_idle;
      chk(q[2:0], `ST_DISABLED);
      bus(`REG_COMMAND, 1'b1, `CMD_BEGIN_ALIGN);
      pulse(1);
      @(posedge hclk);
      chk(axis_enabled, 1'b1);
      wait_idle;
      chk(n_al, v);
      chk(q[2:0], `ST_DISABLED);
      $display("Test no search done");
      wrap_up;
   end
endmodule
